// File: dpsa_pkg.sv
package dpsa_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int IDX_W = 3;
  localparam int NUM_FLAGS = 8;
  // Cycles of each access phase at 10 MHz.
  localparam int SETUP_NS = 100;
  localparam int STROBE_NS = 200;
  localparam int CLK_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [IDX_W-1:0] IDX_ZERO = 3'h0;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;

  typedef enum logic [2:0] {
    DPSA_IDLE = 3'b000,
    DPSA_SETUP = 3'b001,
    DPSA_STROBE = 3'b011,
    DPSA_RECOVER = 3'b010,
    DPSA_INIT = 3'b110
  } dpsa_state_t;

  // Pins that the controller drives toward one port of the device.
  typedef struct packed {
    logic chip_enable_n;
    logic semaphore_select_n;
    logic output_enable_n;
    logic read_write_n;
    logic [ADDR_W-1:0] addr;
  } dpsa_port_ctl_t;

  // A user command: claim, release or test one flag.
  typedef struct packed {
    logic is_write;
    logic flag_data_bit;
    logic [IDX_W-1:0] index;
  } dpsa_cmd_t;
endpackage

// File: dpsa_host.sv
`timescale 1ns/1ns
module dpsa_host (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire dpsa_pkg::dpsa_cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_owned,
  output logic init_done,
  output dpsa_pkg::dpsa_port_ctl_t port_ctl,
  input wire logic [dpsa_pkg::DATA_W-1:0] data_in,
  output logic [dpsa_pkg::DATA_W-1:0] data_out,
  output logic data_oe
);
  import dpsa_pkg::*;

  // --------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_sync;

  // The device drives data asynchronously, so it crosses two flops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      data_meta <= data_in;
      data_sync <= data_meta;
    end
  end

  // --------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------
  dpsa_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [IDX_W-1:0] idx, next_idx;
  logic wr, next_wr;
  logic bit0, next_bit0;
  logic done, next_done;
  logic rv, next_rv;
  logic own, next_own;

  // Next values. Every access passes through recovery with select and output
  // enable released, so the device recaptures on the next read.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_idx = idx;
    next_wr = wr;
    next_bit0 = bit0;
    next_done = done;
    next_rv = 1'b0;
    next_own = own;
    case (state)
      DPSA_INIT: begin
        // Flags power up unknown, so release every one first.
        next_wr = 1'b1;
        next_bit0 = 1'b1;
        next_cnt = CNT_ZERO;
        next_state = DPSA_SETUP;
      end
      DPSA_IDLE: begin
        if (cmd_valid) begin
          next_idx = cmd.index;
          next_wr = cmd.is_write;
          next_bit0 = cmd.flag_data_bit;
          next_cnt = CNT_ZERO;
          next_state = DPSA_SETUP;
        end
      end
      DPSA_SETUP: begin
        // Address and select settle before the strobe opens.
        if (cnt == CNT_W'(SETUP_CYC - 1)) begin
          next_cnt = CNT_ZERO;
          next_state = DPSA_STROBE;
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
      DPSA_STROBE: begin
        if (cnt == CNT_W'(STROBE_CYC - 1)) begin
          next_cnt = CNT_ZERO;
          next_state = DPSA_RECOVER;
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
      default: begin
        // Recovery cycle: every control pin is inactive here.
        // The synchroniser lags the pin by two edges, so the read value
        // is taken here, after the strobe, and not inside it.
        if (!wr) begin
          next_own = ~data_sync[0];
        end
        if (!done) begin
          if (idx == IDX_LAST) begin
            next_done = 1'b1;
            next_state = DPSA_IDLE;
          end else begin
            next_idx = idx + 3'h1;
            next_state = DPSA_INIT;
          end
        end else begin
          next_rv = 1'b1;
          next_state = DPSA_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= DPSA_INIT;
      cnt <= CNT_ZERO;
      idx <= IDX_ZERO;
      wr <= 1'b1;
      bit0 <= 1'b1;
      done <= 1'b0;
      rv <= 1'b0;
      own <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      wr <= next_wr;
      bit0 <= next_bit0;
      done <= next_done;
      rv <= next_rv;
      own <= next_own;
    end
  end

  // --------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------
  logic active;
  logic [ADDR_W-1:0] addr_word;

  // Only the low index lines matter; upper address is held at zero.
  // Pins follow the next state, so select and address lead the strobe.
  always_comb begin
    active = (next_state == DPSA_SETUP) || (next_state == DPSA_STROBE);
    addr_word = '0;
    addr_word[IDX_W-1:0] = next_idx;
  end

  // Chip enable stays high: semaphore access never touches the array.
  // That also keeps any master busy decision out of a width cascade.
  // Outside an access both selects are high, the device idles.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_ctl <= '{1'b1, 1'b1, 1'b1, 1'b1, '0};
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      port_ctl.chip_enable_n <= 1'b1;
      port_ctl.semaphore_select_n <= ~active;
      port_ctl.output_enable_n <= ~(next_state == DPSA_STROBE && !next_wr);
      port_ctl.read_write_n <= ~(next_state == DPSA_STROBE && next_wr);
      port_ctl.addr <= addr_word;
      data_out <= {DATA_W{next_bit0}};
      data_oe <= active && next_wr;
    end
  end

  // A claim is write zero then a separate read command to confirm.
  assign cmd_ready = (state == DPSA_IDLE) && done;
  assign rsp_valid = rv;
  assign rsp_owned = own;
  assign init_done = done;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence s_strobe_rd;
    !port_ctl.output_enable_n && !port_ctl.semaphore_select_n;
  endsequence

  sequence s_open_read;
    $fell(port_ctl.output_enable_n);
  endsequence

  // Both selects close after a read, so the next poll recaptures.
  a_poll_release: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_strobe_rd ##1 port_ctl.output_enable_n |-> ##[0:3]
      port_ctl.semaphore_select_n)
    else $error("Select not released between reads.");
  a_no_array: assert property (
    @(posedge clock) disable iff (!rst_n)
    port_ctl.chip_enable_n)
    else $error("Chip enable driven during semaphore use.");
  a_upper_zero: assert property (
    @(posedge clock) disable iff (!rst_n)
    port_ctl.addr[ADDR_W-1:IDX_W] == '0)
    else $error("Upper address lines not zero.");
  a_write_data: assert property (
    @(posedge clock) disable iff (!rst_n)
    !port_ctl.read_write_n |-> data_oe)
    else $error("Write strobe without data drive.");
  a_setup_first: assert property (
    @(posedge clock) disable iff (!rst_n)
    $fell(port_ctl.read_write_n) |-> !$past(port_ctl.semaphore_select_n))
    else $error("Write strobe before address setup.");
  // A moving address under the write strobe could corrupt another flag.
  a_addr_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    !port_ctl.read_write_n |=> port_ctl.read_write_n
      || $stable(port_ctl.addr))
    else $error("Address moved during write strobe.");
  a_init_free: assert property (
    @(posedge clock) disable iff (!rst_n)
    !done && data_oe |-> data_out == {DATA_W{1'b1}})
    else $error("Start-up write is not a release.");
  a_rsp_pulse: assert property (
    @(posedge clock) disable iff (!rst_n)
    rsp_valid |=> !rsp_valid)
    else $error("Response lasted more than one cycle.");
  a_no_both: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(!port_ctl.output_enable_n && !port_ctl.read_write_n))
    else $error("Read and write strobes together.");
  // An idle cycle between accesses lets the device drop its captured view.
  a_select_gap: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(port_ctl.semaphore_select_n) |=> port_ctl.semaphore_select_n)
    else $error("Select reopened without an idle cycle.");
  // The read strobe must outlast the synchroniser's first stage.
  a_read_open: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_open_read |=> !port_ctl.output_enable_n)
    else $error("Read strobe shorter than two cycles.");
endmodule

// File: dpsa_dev_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Device model: eight flags seen from two ports.
// ----------------------------------------
module dpsa_dev_model (
  input wire logic clock,
  input wire dpsa_pkg::dpsa_port_ctl_t ctl,
  input wire logic [dpsa_pkg::DATA_W-1:0] host_dq,
  input wire logic host_oe,
  input wire logic right_wr,
  input wire logic right_bit,
  input wire logic [dpsa_pkg::IDX_W-1:0] right_idx,
  output logic [dpsa_pkg::DATA_W-1:0] dq,
  output logic [dpsa_pkg::NUM_FLAGS-1:0] own_l,
  output logic [dpsa_pkg::NUM_FLAGS-1:0] own_r
);
  import dpsa_pkg::*;
  // The right side of this model only touches semaphores, never the array.
  localparam logic RIGHT_CE_N = 1'b1;
  localparam logic ROLE_MASTER = 1'b1;
  // Latches power up as requests, so the flags start claimed and a host
  // that skips its release sweep fails.
  logic [NUM_FLAGS-1:0] req_l = '0;
  logic [NUM_FLAGS-1:0] req_r = '0;
  logic [NUM_FLAGS-1:0] hold_l = '0;
  logic [NUM_FLAGS-1:0] hold_r = '0;
  logic [DATA_W-1:0] last = '0;
  logic cap = 1'b1;
  logic act;
  logic standby_l;
  logic busy_l_n;
  assign own_l = hold_l;
  assign own_r = hold_r;
  assign act = !ctl.semaphore_select_n && !ctl.output_enable_n;
  assign standby_l = ctl.chip_enable_n && ctl.semaphore_select_n;
  // Busy looks at chip enables and the master role only; never low on both sides.
  assign busy_l_n = !(ROLE_MASTER && !ctl.chip_enable_n
    && !RIGHT_CE_N);
  // The view is frozen as the read opens; a poll must reopen it.
  always @(posedge act) cap = !hold_l[ctl.addr[2:0]];
  // A released bus shows the inverse of its last value, never a stale copy.
  always_comb dq = act ? {DATA_W{cap}} : ~last;
  always @(posedge clock) if (!standby_l && act) last <= dq;
  // Writes land in request latches; the flag follows without wait states.
  // Working copies let the outputs change only by non-blocking update.
  always @(posedge clock) begin : flag_update
    logic [NUM_FLAGS-1:0] rl, rr, hl, hr;
    rl = req_l;
    rr = req_r;
    hl = hold_l;
    hr = hold_r;
    // A write is dropped while busy is low, as on an inhibited port.
    if (!ctl.semaphore_select_n && !ctl.read_write_n && host_oe
      && busy_l_n) begin
      rl[ctl.addr[2:0]] = host_dq[0];
    end
    if (right_wr) rr[right_idx] = right_bit;
    for (int i = 0; i < NUM_FLAGS; i++) begin
      if (hl[i] && rl[i]) hl[i] = 1'b0;
      if (hr[i] && rr[i]) hr[i] = 1'b0;
      if (!hl[i] && !hr[i]) begin
        hl[i] = !rl[i];
        hr[i] = rr[i] ? 1'b0 : rl[i];
      end
    end
    req_l <= rl;
    req_r <= rr;
    hold_l <= hl;
    hold_r <= hr;
  end
endmodule

// File: test_dual_port_semaphore_arbiter.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bench: host on the left port, bench plays the right port.
// ----------------------------------------
module test_dual_port_semaphore_arbiter;
  import dpsa_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  dpsa_cmd_t cmd = 5'h00;
  logic right_wr = 1'b0;
  logic right_bit = 1'b1;
  logic [IDX_W-1:0] right_idx = 3'h0;
  logic cmd_ready, rsp_valid, rsp_owned, init_done, data_oe;
  dpsa_port_ctl_t port_ctl;
  logic [DATA_W-1:0] data_in, data_out;
  logic [NUM_FLAGS-1:0] own_l, own_r;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  dpsa_host dpsa_host_inst (.clock(clock), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_owned(rsp_owned), .init_done(init_done),
    .port_ctl(port_ctl), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe));
  dpsa_dev_model dpsa_dev_model_inst (.clock(clock), .ctl(port_ctl),
    .host_dq(data_out), .host_oe(data_oe), .right_wr(right_wr),
    .right_bit(right_bit), .right_idx(right_idx), .dq(data_in),
    .own_l(own_l), .own_r(own_r));
  initial forever #50 clock = ~clock;
  task automatic conclude();
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  // One host command; a read returns once its response pulse is seen.
  task automatic host_cmd(input logic w, b, input logic [2:0] i);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    cmd <= {w, b, i};
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(posedge clock);
    n = 0;
    while (n < 20 && (w ? cmd_ready !== 1'b1 : rsp_valid !== 1'b1)) begin
      @(posedge clock);
      n++;
    end
    check("command end", n < 20, 1'b1);
  endtask
  task automatic right_write(input logic b, input logic [2:0] i);
    right_wr <= 1'b1;
    right_bit <= b;
    right_idx <= i;
    @(posedge clock);
    right_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic t_init();
    for (int i = 0; i < 100 && init_done !== 1'b1; i++) @(posedge clock);
    check("init_done", init_done, 1'b1);
    for (int i = 0; i < 8; i++) right_write(1'b1, i[2:0]);
    check("left owned", own_l, 8'h00);
    check("right owned", own_r, 8'h00);
    for (int i = 0; i < 8; i++) begin
      host_cmd(1'b0, 1'b0, i[2:0]);
      check("free read", rsp_owned, 1'b0);
    end
  endtask
  task automatic t_claim();
    host_cmd(1'b1, 1'b0, 3'h3);
    host_cmd(1'b0, 1'b0, 3'h3);
    check("claim read", rsp_owned, 1'b1);
    check("right view", own_r[3], 1'b0);
    host_cmd(1'b1, 1'b1, 3'h3);
    check("released", own_l, 8'h00);
  endtask
  task automatic t_contend();
    right_write(1'b0, 3'h5);
    host_cmd(1'b1, 1'b0, 3'h5);
    host_cmd(1'b0, 1'b0, 3'h5);
    check("held read", rsp_owned, 1'b0);
    check("right keeps", own_r[5], 1'b1);
    right_write(1'b1, 3'h5);
    host_cmd(1'b0, 1'b0, 3'h5);
    check("pending read", rsp_owned, 1'b1);
    host_cmd(1'b1, 1'b1, 3'h5);
    check("after free", own_l | own_r, 8'h00);
  endtask
  task automatic t_index();
    for (int i = 0; i < 8; i++) begin
      host_cmd(1'b1, 1'b0, i[2:0]);
      check("one flag", own_l, 8'h01 << i);
      host_cmd(1'b1, 1'b1, i[2:0]);
    end
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_init();
    t_claim();
    t_contend();
    t_index();
    conclude();
  end
endmodule
